// *** hw/fwp_protect_core.v ***
// flash write protection logic: guard bits, one-time space, latch, block protect, freeze
`timescale 1ns/10ps
`include "fwp_regs.vh"
module fwp_protect_core #(
  parameter SECTOR_BITS = 6,
  parameter ADDR_BITS = 24
) (
  // clock and reset (reset = power-on)
  input wire clk,
  input wire rst_n,
  // decoded command stream from serial front end
  input wire cmdStart,
  input wire [7:0] cmdCode,
  input wire [ADDR_BITS-1:0] cmdAddr,
  input wire dataValid,
  input wire [7:0] dataByte,
  input wire readReq,
  input wire cmdEnd,
  // device pins
  input wire writeProtectPin_n,
  input wire resetPin_n,
  // persistent guard bits from non-volatile store
  input wire [(1<<SECTOR_BITS)-1:0] persistentSectorGuardBit,
  // read answer
  output reg [7:0] readData,
  output reg readValid,
  // main array write or erase permission
  output reg arrayGrant,
  // register and protection state
  output wire [7:0] statusRegisterOne,
  output reg [7:0] configReg,
  output reg writeEnableLatch,
  output reg [(1<<SECTOR_BITS)-1:0] volatileSectorGuardBit,
  output reg [(1<<SECTOR_BITS)-1:0] sectorProtectMap,
  output reg [`FWP_OTP_CHUNKS-1:0] otpEccOff
);
  localparam SECTORS = 1 << SECTOR_BITS;
  localparam HI = ADDR_BITS - 1;

  // ---- pin synchronisers: 3 flops, change taken when 2nd and 3rd agree
  reg [2:0] wpSync;
  reg [2:0] rstPinSync;
  reg wpLevel;
  reg rstPinLevel;

  always @(posedge clk) begin
    if (!rst_n) begin
      wpSync <= 3'h7;
      rstPinSync <= 3'h7;
      wpLevel <= 1'b1;
      rstPinLevel <= 1'b1;
    end else begin
      wpSync <= {wpSync[1:0], writeProtectPin_n};
      rstPinSync <= {rstPinSync[1:0], resetPin_n};
      if (wpSync[1] == wpSync[2]) begin
        wpLevel <= wpSync[2];
      end
      if (rstPinSync[1] == rstPinSync[2]) begin
        rstPinLevel <= rstPinSync[2];
      end
    end
  end

  wire hwReset = !rstPinLevel;

  // ---- status and config state
  reg [2:0] rangeGuard;
  reg statusWriteDisable;
  reg programError;

  wire freeze = configReg[`FWP_CR_FREEZE];
  wire topBottomSel = configReg[`FWP_CR_TBSEL];

  assign statusRegisterOne = {statusWriteDisable, programError, 1'b0, rangeGuard, writeEnableLatch, 1'b0};

  // ---- command context
  reg [7:0] activeCmd;
  reg [HI:0] opAddr;
  reg [1:0] byteCount;
  reg [7:0] wrrStatus;
  reg [7:0] wrrConfig;
  reg [7:0] guardByte;
  reg otpStartInRange;

  wire isCmd = activeCmd != `FWP_CMD_NONE;
  wire [SECTOR_BITS-1:0] opSector = opAddr[HI:HI-SECTOR_BITS+1];
  wire otpInRange = opAddr[HI:`FWP_OTP_ADDR_BITS] == {(ADDR_BITS-`FWP_OTP_ADDR_BITS){1'b0}};
  wire [`FWP_OTP_ADDR_BITS-1:0] otpAddr = opAddr[`FWP_OTP_ADDR_BITS-1:0];

  always @(posedge clk) begin
    if (!rst_n || hwReset) begin
      activeCmd <= `FWP_CMD_NONE;
      opAddr <= {ADDR_BITS{1'b0}};
      byteCount <= 2'h0;
      wrrStatus <= 8'h00;
      wrrConfig <= 8'h00;
      guardByte <= 8'h00;
      otpStartInRange <= 1'b0;
    end else if (cmdStart) begin
      activeCmd <= cmdCode;
      opAddr <= cmdAddr;
      byteCount <= 2'h0;
      otpStartInRange <= cmdAddr[HI:`FWP_OTP_ADDR_BITS] == {(ADDR_BITS-`FWP_OTP_ADDR_BITS){1'b0}};
    end else if (cmdEnd) begin
      activeCmd <= `FWP_CMD_NONE;
    end else if (isCmd) begin
      if (dataValid) begin
        if (byteCount == 2'h0) begin
          wrrStatus <= dataByte;
          guardByte <= dataByte;
        end
        if (byteCount == 2'h1) begin
          wrrConfig <= dataByte;
        end
        if (byteCount != 2'h3) begin
          byteCount <= byteCount + 2'h1;
        end
      end
      // one-time accesses walk the address, like fast read and page program
      if ((dataValid && activeCmd == `FWP_CMD_ONETIME_PROGRAM) ||
          (readReq && activeCmd == `FWP_CMD_ONETIME_READ)) begin
        opAddr <= opAddr + {{(ADDR_BITS-1){1'b0}}, 1'b1}; // RULE_04 RULE_05
      end
    end
  end

  // ---- one-time space storage (never erased; written flags clear at power-on reset, so content then reads FFh)
  reg [7:0] otpMem [0:`FWP_OTP_BYTES-1];
  reg [`FWP_OTP_BYTES-1:0] otpWritten;
  reg [`FWP_OTP_CHUNKS-1:0] chunkTouched;
  reg [`FWP_OTP_CHUNKS-1:0] chunkUsed;

  wire [7:0] otpCell = otpWritten[otpAddr] ? otpMem[otpAddr] : `FWP_ERASED_BYTE;
  wire [7:0] lockByte0 = otpWritten[`FWP_OTP_LOCK_BASE] ? otpMem[`FWP_OTP_LOCK_BASE] : `FWP_ERASED_BYTE;
  wire [7:0] lockByte1 = otpWritten[`FWP_OTP_LOCK_BASE + 10'h1] ? otpMem[`FWP_OTP_LOCK_BASE + 10'h1] :
    `FWP_ERASED_BYTE;
  wire [7:0] lockByte2 = otpWritten[`FWP_OTP_LOCK_BASE + 10'h2] ? otpMem[`FWP_OTP_LOCK_BASE + 10'h2] :
    `FWP_ERASED_BYTE;
  wire [7:0] lockByte3 = otpWritten[`FWP_OTP_LOCK_BASE + 10'h3] ? otpMem[`FWP_OTP_LOCK_BASE + 10'h3] :
    `FWP_ERASED_BYTE;
  // byte n, bit b guards region 8n+b; region 0 covers the lock bytes themselves
  wire [`FWP_OTP_REGIONS-1:0] regionOpen = {lockByte3, lockByte2, lockByte1, lockByte0}; // RULE_09 RULE_10
  wire regionLocked = !regionOpen[otpAddr[`FWP_OTP_ADDR_BITS-1:5]]; // RULE_03 RULE_09 RULE_10

  // write allowed only with latch, no freeze, valid start and address, open region
  wire otpProgramByte = isCmd && dataValid && activeCmd == `FWP_CMD_ONETIME_PROGRAM &&
    writeEnableLatch && !freeze && otpStartInRange && otpInRange && !regionLocked; // RULE_07 RULE_08 RULE_22

  always @(posedge clk) begin
    if (otpProgramByte) begin
      // programming only moves bits toward 0, so repeats are harmless
      otpMem[otpAddr] <= otpCell & dataByte; // RULE_05
    end
  end

  always @(posedge clk) begin
    if (!rst_n) begin
      otpWritten <= {`FWP_OTP_BYTES{1'b0}};
    end else if (otpProgramByte) begin
      otpWritten[otpAddr] <= 1'b1;
    end
  end

  // ---- correction bookkeeping per 16-byte chunk
  wire otpCmdDone = cmdEnd && activeCmd == `FWP_CMD_ONETIME_PROGRAM;

  always @(posedge clk) begin
    if (!rst_n) begin
      chunkTouched <= {`FWP_OTP_CHUNKS{1'b0}};
      chunkUsed <= {`FWP_OTP_CHUNKS{1'b0}};
      otpEccOff <= {`FWP_OTP_CHUNKS{1'b0}};
    end else if (cmdStart) begin
      chunkTouched <= {`FWP_OTP_CHUNKS{1'b0}};
    end else if (otpCmdDone) begin
      otpEccOff <= otpEccOff | (chunkUsed & chunkTouched); // RULE_06
      chunkUsed <= chunkUsed | chunkTouched; // RULE_06
    end else if (otpProgramByte) begin
      chunkTouched[otpAddr[`FWP_OTP_ADDR_BITS-1:4]] <= 1'b1;
    end
  end

  // ---- sector protection map
  wire [SECTORS-1:0] rangeCovered;
  genvar s;
  generate
    for (s = 0; s < SECTORS; s = s + 1) begin : gSector
      // genvar cannot be part-selected; a sized constant carries the index
      localparam [SECTOR_BITS-1:0] SECTOR_IDX = s;
      fwp_range_check #(
        .IDX_BITS(SECTOR_BITS)
      ) uRange (
        .sectorIndex(SECTOR_IDX),
        .rangeCode(rangeGuard),
        .topBottomSelect(topBottomSel),
        .covered(rangeCovered[s])
      );
    end
  endgenerate

  // either guard bit at 0, or block range, protects a sector
  wire [SECTORS-1:0] protectNow = rangeCovered | ~persistentSectorGuardBit | ~volatileSectorGuardBit; // RULE_15 RULE_21

  always @(posedge clk) begin
    if (!rst_n) begin
      sectorProtectMap <= {SECTORS{1'b0}};
    end else begin
      sectorProtectMap <= protectNow;
    end
  end

  // ---- array program and erase decision at command end
  wire isArrayWrite = activeCmd == `FWP_CMD_PAGE_PROGRAM || activeCmd == `FWP_CMD_QUAD_PAGE_PROGRAM ||
    activeCmd == `FWP_CMD_SECTOR_ERASE;
  wire isBulk = activeCmd == `FWP_CMD_BULK_ERASE;
  wire arrayBlocked = isBulk ? (|protectNow) : protectNow[opSector];
  wire arrayDone = cmdEnd && (isArrayWrite || isBulk);

  always @(posedge clk) begin
    if (!rst_n || hwReset) begin
      arrayGrant <= 1'b0;
    end else begin
      arrayGrant <= arrayDone && writeEnableLatch && !arrayBlocked; // RULE_11 RULE_15 RULE_22
    end
  end

  // ---- volatile guard bits
  wire guardWriteDone = cmdEnd && activeCmd == `FWP_CMD_GUARD_WRITE && byteCount != 2'h0;

  always @(posedge clk) begin
    if (!rst_n || hwReset) begin
      volatileSectorGuardBit <= {SECTORS{`FWP_GUARD_RESET}}; // RULE_01
    end else if (guardWriteDone) begin
      if (guardByte == `FWP_GUARD_CLEAR) begin
        volatileSectorGuardBit[opSector] <= 1'b0; // RULE_01 RULE_02
      end else if (guardByte == `FWP_GUARD_SET) begin
        volatileSectorGuardBit[opSector] <= 1'b1; // RULE_01 RULE_02
      end
    end
  end

  // ---- register write and freeze
  wire regWriteDone = cmdEnd && activeCmd == `FWP_CMD_REG_WRITE && writeEnableLatch;
  wire regLocked = !wpLevel && statusWriteDisable; // RULE_20
  reg [7:0] next_configReg;

  always @* begin
    next_configReg = wrrConfig;
    next_configReg[`FWP_CR_FREEZE] = freeze | wrrConfig[`FWP_CR_FREEZE]; // RULE_18
    if (freeze) begin
      next_configReg[`FWP_CR_TBSEL] = topBottomSel; // RULE_17
    end
  end

  always @(posedge clk) begin
    if (!rst_n) begin
      rangeGuard <= `FWP_BP_RESET;
      statusWriteDisable <= 1'b0;
      configReg <= `FWP_CR_RESET; // RULE_18
    end else if (regWriteDone && !regLocked && byteCount != 2'h0) begin // RULE_20
      statusWriteDisable <= wrrStatus[`FWP_SR1_STATUS_WRITE_DISABLE];
      if (!freeze) begin
        rangeGuard <= wrrStatus[4:2]; // RULE_17 RULE_19
      end
      if (byteCount != 2'h1) begin
        configReg <= next_configReg;
      end
    end
  end

  // ---- program error flag
  wire otpFrozenFail = otpCmdDone && writeEnableLatch && freeze; // RULE_08
  wire arrayFail = arrayDone && writeEnableLatch && arrayBlocked;

  always @(posedge clk) begin
    if (!rst_n || hwReset) begin
      programError <= 1'b0;
    end else if (otpFrozenFail || arrayFail) begin
      programError <= 1'b1; // RULE_08
    end else if (cmdEnd && activeCmd == `FWP_CMD_CLEAR_STATUS) begin
      programError <= 1'b0;
    end
  end

  // ---- write-enable latch
  wire welClearCmd = activeCmd == `FWP_CMD_SOFT_RESET || activeCmd == `FWP_CMD_WRITE_DISABLE ||
    activeCmd == `FWP_CMD_REG_WRITE || isArrayWrite || isBulk;
  // out-of-range or frozen one-time program leaves the latch standing
  wire otpClears = otpCmdDone && otpStartInRange && !freeze; // RULE_07 RULE_08

  always @(posedge clk) begin
    if (!rst_n || hwReset) begin
      writeEnableLatch <= 1'b0; // RULE_12
    end else if (cmdEnd && activeCmd == `FWP_CMD_WRITE_ENABLE) begin
      writeEnableLatch <= 1'b1; // RULE_11
    end else if ((cmdEnd && welClearCmd) || otpClears) begin
      writeEnableLatch <= 1'b0; // RULE_12
    end
  end

  // ---- read answers
  always @(posedge clk) begin
    if (!rst_n || hwReset) begin
      readData <= 8'h00;
      readValid <= 1'b0;
    end else begin
      readValid <= 1'b0;
      if (isCmd && readReq && activeCmd == `FWP_CMD_GUARD_READ) begin
        readData <= volatileSectorGuardBit[opSector] ? `FWP_GUARD_SET : `FWP_GUARD_CLEAR; // RULE_02
        readValid <= 1'b1;
      end else if (isCmd && readReq && activeCmd == `FWP_CMD_ONETIME_READ) begin
        // beyond the space the answer is undefined; erased value is given
        readData <= otpInRange ? otpCell : `FWP_ERASED_BYTE; // RULE_04
        readValid <= 1'b1;
      end
    end
  end
endmodule

// *** hw/fwp_range_check.v ***
// block-protect range decode for one sector
`timescale 1ns/10ps
module fwp_range_check #(
  parameter IDX_BITS = 6
) (
  // sector under test
  input wire [IDX_BITS-1:0] sectorIndex,
  // block-protect code and direction
  input wire [2:0] rangeCode,
  input wire topBottomSelect,
  // result
  output wire covered
);
  localparam [IDX_BITS:0] TOTAL = {1'b1, {IDX_BITS{1'b0}}};
  localparam [IDX_BITS:0] ONE = {{IDX_BITS{1'b0}}, 1'b1};

  wire [2:0] shiftBy = rangeCode - 3'h1;
  wire [IDX_BITS:0] span = (rangeCode == 3'h0) ? {(IDX_BITS+1){1'b0}} : (ONE << shiftBy);
  wire [IDX_BITS:0] index = {1'b0, sectorIndex};
  wire inTop = (rangeCode != 3'h0) && (index >= (TOTAL - span)); // RULE_13
  wire inBottom = index < span; // RULE_14

  // code 111 always means whole array
  assign covered = (rangeCode == 3'h7) || (topBottomSelect ? inBottom : inTop);
endmodule

// *** hw/fwp_regs.vh ***
// command codes, register fields, reset values and geometry for the flash write protection logic
// Summary of operation
// RULE_01: one volatile guard bit per sector, reset to 1; 00h clears, FFh sets.
// RULE_02: command E0h reads and E1h writes the addressed sector's volatile guard byte.
// RULE_03: 1024-byte one-time space, 32 aligned 32-byte regions, each lockable alone.
// RULE_04: one-time read follows fast-read sequence; beyond 1 kB data is undefined.
// RULE_05: one-time program uses page-program sequence, may repeat; never erased.
// RULE_06: first program of a 16-byte chunk keeps correction; a second disables it.
// RULE_07: one-time program outside valid range is ignored; write-enable latch stays 1.
// RULE_08: with freeze set, one-time program writes nothing and sets program-error flag.
// RULE_09: each lock byte guards eight regions, bit 0 lowest; programmed bit blocks region.
// RULE_10: bit 0 of byte 0x10 guards the lock and reserved bytes of region 0.
// RULE_11: write-enable command sets the latch; needed before non-volatile changes.
// RULE_12: latch clears at reset and after reset, programs, erases, disable, register write.
// RULE_13: top/bottom select 0: block-protect code counts range down from array top.
// RULE_14: top/bottom select 1: same range sizes counted up from address zero.
// RULE_15: sector is protected when block protection or sector protection covers it.
// RULE_16: host should use block protection or sector protection, not both.
// RULE_17: config bit 0 is freeze; it holds block-protect and top/bottom select bits.
// RULE_18: freeze, once 1, is cleared by no command, only by power-on reset.
// RULE_19: register write changing block-protect bits under freeze is ignored, no error.
// RULE_20: write-protect pin low with status write disable 1 blocks register changes.
// RULE_21: persistent or volatile guard bit at 0 protects the sector.
// RULE_22: program or erase on protected sector or locked region changes nothing.
`ifndef FWP_REGS_VH
`define FWP_REGS_VH

// command codes
`define FWP_CMD_REG_WRITE 8'h01
`define FWP_CMD_PAGE_PROGRAM 8'h02
`define FWP_CMD_WRITE_DISABLE 8'h04
`define FWP_CMD_WRITE_ENABLE 8'h06
`define FWP_CMD_CLEAR_STATUS 8'h30
`define FWP_CMD_QUAD_PAGE_PROGRAM 8'h32
`define FWP_CMD_ONETIME_PROGRAM 8'h42
`define FWP_CMD_ONETIME_READ 8'h4b
`define FWP_CMD_BULK_ERASE 8'h60
`define FWP_CMD_SECTOR_ERASE 8'hd8
`define FWP_CMD_GUARD_READ 8'he0
`define FWP_CMD_GUARD_WRITE 8'he1
`define FWP_CMD_SOFT_RESET 8'hf0
`define FWP_CMD_NONE 8'h00

// status register one fields
`define FWP_SR1_WEL 1
`define FWP_SR1_PERR 6
`define FWP_SR1_STATUS_WRITE_DISABLE 7
// config register fields
`define FWP_CR_FREEZE 0
`define FWP_CR_TBSEL 5

// reset values
`define FWP_CR_RESET 8'h00
`define FWP_BP_RESET 3'h0
`define FWP_GUARD_RESET 1'b1
`define FWP_GUARD_CLEAR 8'h00
`define FWP_GUARD_SET 8'hff
`define FWP_ERASED_BYTE 8'hff

// one-time space geometry
`define FWP_OTP_ADDR_BITS 10
`define FWP_OTP_BYTES 1024
`define FWP_OTP_CHUNKS 64
`define FWP_OTP_REGIONS 32
`define FWP_OTP_LOCK_BASE 10'h010

`endif

// *** sim/flash_write_protection_logic_test.sv ***
// self-checking bench for the protection core
`timescale 1ns/10ps
module flash_write_protection_logic_test;
  logic clk = 0, rst_n = 0, wpPin_n = 1, hwRst_n = 1;
  logic [63:0] persistent_sector_guard_bit = '1;
  wire cmdStart, dataValid, readReq, cmdEnd, readValid, arrayGrant, write_enable_latch;
  wire [7:0] cmdCode, dataByte, readData, sr1, cfg;
  wire [23:0] cmdAddr;
  wire [63:0] volatile_sector_guard_bit, pmap, ecc;
  int bad_count = 0, n_compared = 0, cyc = 0, grants = 0, n;
  logic [7:0] q;
  logic [63:0] e;
  logic [7:0] clr [8] = '{8'h02, 8'h32, 8'hd8, 8'h60, 8'h04, 8'h01, 8'h42, 8'hf0};
  logic [23:0] la [3] = '{24'h000014, 24'h000030, 24'h000040};
  always #5 clk = ~clk;
  fwp_host_model host (.clk(clk), .readData(readData), .cmdStart(cmdStart), .dataValid(dataValid),
    .readReq(readReq), .cmdEnd(cmdEnd), .cmdCode(cmdCode), .dataByte(dataByte), .cmdAddr(cmdAddr));
  fwp_protect_core dut (.clk(clk), .rst_n(rst_n), .cmdStart(cmdStart), .cmdCode(cmdCode), .cmdAddr(cmdAddr),
    .dataValid(dataValid), .dataByte(dataByte), .readReq(readReq), .cmdEnd(cmdEnd), .writeProtectPin_n(wpPin_n),
    .resetPin_n(hwRst_n), .persistentSectorGuardBit(persistent_sector_guard_bit), .readData(readData), .readValid(readValid),
    .arrayGrant(arrayGrant), .statusRegisterOne(sr1), .configReg(cfg), .writeEnableLatch(write_enable_latch),
    .volatileSectorGuardBit(volatile_sector_guard_bit), .sectorProtectMap(pmap), .otpEccOff(ecc));
  always @(posedge clk) begin
    if (arrayGrant === 1'b1) grants++;
    cyc++;
    if (cyc == 5000) begin
      bad_count++;
      end_sim;
    end
  end
  task end_sim;
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task chk(input logic [63:0] got, input logic [63:0] exp, input string m);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task cmd(input [7:0] code, input [23:0] a = 0, input int k = 0, input [15:0] d = 0, input bit rd = 0);
    host.run(code, a, k, d, rd, q);
  endtask
  task register_write_cmd(input [7:0] s, input [7:0] c);
    cmd(8'h06);
    cmd(8'h01, 0, 2, {c, s});
  endtask
  initial begin
    repeat (12) @(negedge clk);
    rst_n = 1;
    @(negedge clk);
    chk({write_enable_latch, cfg, sr1}, 0, "reset regs");
    chk(volatile_sector_guard_bit, '1, "guard reset");
    foreach (clr[i]) begin
      cmd(8'h06);
      chk(write_enable_latch, 1, "latch set");
      cmd(clr[i], clr[i] == 8'h42 ? 24'h000100 : 24'h040000, clr[i] == 8'h01 || clr[i] == 8'h42);
      chk(write_enable_latch, 0, "latch clear");
    end
    $display("test latch done");
    cmd(8'he1, 24'h140000, 1, 16'h0000);
    cmd(8'he0, 24'h140000, 0, 0, 1);
    chk(q, 8'h00, "guard read");
    chk(pmap, 64'h20, "guard map");
    cmd(8'h06);
    n = grants;
    cmd(8'h02, 24'h140000);
    chk({sr1[6], grants}, {1'b1, n}, "protected program");
    cmd(8'h30);
    cmd(8'h06);
    cmd(8'h02, 24'h180000);
    chk(grants, n + 1, "open program");
    cmd(8'he1, 24'h140000, 1, 16'h005a);
    chk(volatile_sector_guard_bit[5], 0, "odd guard value");
    cmd(8'he1, 24'h140000, 1, 16'h00ff);
    cmd(8'he0, 24'h140000, 0, 0, 1);
    chk(q, 8'hff, "guard set");
    persistent_sector_guard_bit[7] = 0;
    repeat (3) @(negedge clk);
    chk(pmap, 64'h80, "persistent map");
    persistent_sector_guard_bit = '1;
    $display("test guard done");
    for (int t = 0; t < 16; t++) begin
      register_write_cmd({3'h0, t[2:0], 2'h0}, {2'h0, t[3], 5'h00});
      n = t[2:0] == 0 ? 0 : 1 << (t[2:0] - 1);
      e = t[3] ? (64'h1 << n) - 1 : ~((64'h1 << (64 - n)) - 1);
      chk(pmap, e, "range map");
    end
    $display("test range done");
    register_write_cmd(8'h80, 8'h00);
    wpPin_n = 0;
    repeat (6) @(negedge clk);
    register_write_cmd(8'h80, 8'h20);
    chk(cfg, 0, "locked write");
    wpPin_n = 1;
    repeat (6) @(negedge clk);
    register_write_cmd(8'h00, 8'h00);
    chk(sr1[7], 0, "unlocked write");
    $display("test pin done");
    cmd(8'h06);
    cmd(8'h42, 24'h000020, 1, 16'h003c);
    cmd(8'h4b, 24'h000020, 0, 0, 1);
    chk({q, ecc[2]}, {8'h3c, 1'b0}, "otp first");
    cmd(8'h06);
    cmd(8'h42, 24'h000021, 1, 16'h00ff);
    chk(ecc[2], 1, "otp second");
    cmd(8'h06);
    cmd(8'h42, 24'h000400, 1, 0);
    chk(write_enable_latch, 1, "otp outside");
    cmd(8'h42, 24'h000010, 1, 16'h00fc);
    foreach (la[i]) begin
      cmd(8'h06);
      cmd(8'h42, la[i], 1, 0);
      cmd(8'h4b, la[i], 0, 0, 1);
      chk(q, i < 2 ? 8'hff : 8'h00, "otp lock");
    end
    $display("test otp done");
    register_write_cmd(8'h04, 8'h01);
    register_write_cmd(8'h1c, 8'h20);
    chk({cfg, sr1}, 16'h0104, "frozen write");
    cmd(8'h06);
    cmd(8'h42, 24'h000040, 1, 0);
    chk(sr1, 8'h46, "otp frozen");
    hwRst_n = 0;
    repeat (8) @(negedge clk);
    hwRst_n = 1;
    repeat (8) @(negedge clk);
    chk({cfg, sr1, volatile_sector_guard_bit[0]}, 17'h00209, "pin reset");
    rst_n = 0;
    repeat (2) @(negedge clk);
    rst_n = 1;
    @(negedge clk);
    chk(cfg, 0, "power reset");
    $display("test freeze done");
    end_sim;
  end
endmodule

// *** sim/fwp_host_model.sv ***
// command stream driver standing in for the serial host
`timescale 1ns/10ps
module fwp_host_model (
  // clock and read answer
  input wire clk,
  input wire [7:0] readData,
  // command stream
  output reg cmdStart, dataValid, readReq, cmdEnd,
  output reg [7:0] cmdCode, dataByte,
  output reg [23:0] cmdAddr
);
  initial {cmdStart, dataValid, readReq, cmdEnd, cmdCode, dataByte, cmdAddr} = 0;
  // one command: n data bytes, then an optional one-byte read
  task run(input [7:0] code, input [23:0] addr, input int n, input [15:0] d, input bit rd, output [7:0] q);
    @(negedge clk);
    {cmdStart, cmdCode, cmdAddr} = {1'b1, code, addr};
    @(negedge clk);
    cmdStart = 0;
    for (int i = 0; i < n; i++) begin
      dataValid = 1;
      dataByte = d[8*i +: 8];
      @(negedge clk);
    end
    dataValid = 0;
    if (rd) begin
      readReq = 1;
      @(negedge clk);
      readReq = 0;
      @(negedge clk);
      q = readData;
    end
    cmdEnd = 1;
    @(negedge clk);
    cmdEnd = 0;
    repeat (3) @(negedge clk);
  endtask
endmodule

// *** sim/fwp_protect_core_asserts.sv ***
// port assertions for the protection core
`timescale 1ns/10ps
`include "fwp_regs.vh"
module fwp_protect_core_asserts #(parameter SECTOR_BITS = 6, parameter ADDR_BITS = 24) (
  // clock, reset, command stream
  input logic clk, rst_n, cmdStart, dataValid, readReq, cmdEnd,
  input logic [7:0] cmdCode, dataByte,
  input logic [ADDR_BITS-1:0] cmdAddr,
  // pins
  input logic writeProtectPin_n, resetPin_n,
  input logic [(1<<SECTOR_BITS)-1:0] persistentSectorGuardBit,
  // outputs
  input logic [7:0] readData, statusRegisterOne, configReg,
  input logic readValid, arrayGrant, writeEnableLatch,
  input logic [(1<<SECTOR_BITS)-1:0] volatileSectorGuardBit, sectorProtectMap,
  input logic [`FWP_OTP_CHUNKS-1:0] otpEccOff
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  wire [SECTOR_BITS-1:0] sec = cmdAddr[ADDR_BITS-1 -: SECTOR_BITS];
  sequence guard_wr_s;
    cmdStart && cmdCode == 8'he1 ##1 dataValid && (dataByte == 8'h00 || dataByte == 8'hff) ##1 cmdEnd;
  endsequence
  sequence guard_rd_s;
    cmdStart && cmdCode == 8'he0 ##1 readReq;
  endsequence
  wel_set_a: assert property (cmdStart && cmdCode == 8'h06 ##1 cmdEnd |=> writeEnableLatch)
    else $error("latch not set");
  wel_clear_a: assert property (cmdStart && cmdCode inside {8'h02, 8'h32, 8'hd8, 8'h60, 8'h04} ##1 cmdEnd
    |=> !writeEnableLatch) else $error("latch not cleared");
  grant_ok_a: assert property (cmdStart && cmdCode == 8'h02 && writeEnableLatch && !sectorProtectMap[sec]
    ##1 cmdEnd |=> arrayGrant) else $error("grant missing");
  grant_block_a: assert property (cmdStart && cmdCode == 8'h02 && sectorProtectMap[sec] ##1 cmdEnd
    |=> !arrayGrant) else $error("grant on protected sector");
  freeze_lock_a: assert property (configReg[0]
    |=> configReg[0] && $stable(statusRegisterOne[4:2]) && $stable(configReg[5])) else $error("frozen bits moved");
  status_write_disable_block_a: assert property (!writeProtectPin_n [*6] ##0 statusRegisterOne[7] |=> $stable(configReg))
    else $error("config changed while locked");
  otp_range_a: assert property (cmdStart && cmdCode == 8'h42 && cmdAddr >= 'h400 && writeEnableLatch
    ##1 dataValid ##1 cmdEnd |=> writeEnableLatch) else $error("latch dropped");
  otp_freeze_a: assert property (cmdStart && cmdCode == 8'h42 && configReg[0] && writeEnableLatch
    ##1 dataValid ##1 cmdEnd |=> statusRegisterOne[6]) else $error("no error under freeze");
  guard_write_a: assert property (guard_wr_s
    |=> volatileSectorGuardBit[$past(sec, 3)] == $past(dataByte[0], 2)) else $error("guard write wrong");
  guard_read_a: assert property (guard_rd_s
    |=> readValid && readData == {8{volatileSectorGuardBit[$past(sec, 2)]}}) else $error("guard read wrong");
endmodule
bind fwp_protect_core fwp_protect_core_asserts #(.SECTOR_BITS(SECTOR_BITS), .ADDR_BITS(ADDR_BITS)) chk (
  .clk(clk), .rst_n(rst_n), .cmdStart(cmdStart), .dataValid(dataValid), .readReq(readReq), .cmdEnd(cmdEnd),
  .cmdCode(cmdCode), .dataByte(dataByte), .cmdAddr(cmdAddr), .writeProtectPin_n(writeProtectPin_n),
  .resetPin_n(resetPin_n), .persistentSectorGuardBit(persistentSectorGuardBit), .readData(readData),
  .statusRegisterOne(statusRegisterOne), .configReg(configReg), .readValid(readValid), .arrayGrant(arrayGrant),
  .writeEnableLatch(writeEnableLatch), .volatileSectorGuardBit(volatileSectorGuardBit),
  .sectorProtectMap(sectorProtectMap), .otpEccOff(otpEccOff));
